// >>> design/crw_top.sv
// Purpose: Subsystem reset, watchdog and shared-bus map control
// Assumes: Avalon-MM slave, 32-bit data, waitrequest answers after one wait cycle
// Notes:   Reset outputs are held for a fixed number of cycles
`timescale 1ns/1ps
module crw_top #(
   parameter longint WD_TIMEOUT_CYC = crw_pkg::WD_TIMEOUT_CYC,
   parameter int     RST_PULSE_CYC  = crw_pkg::RST_PULSE_CYC
) (
   input  wire logic                  sys_clk,
   input  wire logic                  resetn,
   input  wire logic                  clk_en,
   input  wire logic [4:0]            avs_address,
   input  wire logic                  avs_read,
   input  wire logic                  avs_write,
   input  wire logic [31:0]           avs_writedata,
   input  wire logic [3:0]            avs_byteenable,
   output logic [31:0]                avs_readdata,
   output logic                       avs_waitrequest,
   output logic [1:0]                 avs_response,
   input  crw_pkg::crw_bus_req_t      bus_req,
   output crw_pkg::crw_bus_dec_t      bus_dec,
   output crw_pkg::crw_resets_t       rst_out,
   output logic                       processor_disable_bit,
   output logic                       boot_map_active
);
   initial begin
      if (RST_PULSE_CYC < 1 || RST_PULSE_CYC > 255) begin
         $error("reset pulse length out of range");
      end
   end

   // ----------------------------------------------------------------
   // Avalon-MM slave handshake
   // ----------------------------------------------------------------
   logic        ack_q;
   logic        acc;
   logic        wr_stb;
   logic        rd_stb;
   logic        bank;
   logic [3:0]  off;
   logic [31:0] wmask;

   assign acc             = (avs_read || avs_write) && clk_en;
   assign avs_waitrequest = !ack_q;
   assign wr_stb          = avs_write && ack_q && clk_en;
   assign rd_stb          = avs_read && ack_q && clk_en;
   assign bank            = avs_address[4];
   assign off             = avs_address[3:0];
   assign wmask           = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                             {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         ack_q <= 1'b0;
      end else if (clk_en) begin
         ack_q <= acc && !ack_q;
      end
   end

   function automatic logic hit(input logic b, input logic [3:0] o,
                                input logic rb, input logic [3:0] ro);
      return (b == rb) && (o == ro);
   endfunction : hit

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   logic [31:0] reset_q;
   logic [31:0] general_q;
   logic [31:0] general_wr_q;
   logic        large_mem_q;
   logic [31:0] scratch_q;
   logic [31:0] pinalt_q;
   logic        cause_q;
   logic        wd_enabled;
   logic        wd_fire;
   logic        soft_req;
   logic        chip_req;
   logic        swc_req;
   logic [7:0]  cpu_cnt_q;
   logic [7:0]  sub_cnt_q;
   logic [7:0]  chip_cnt_q;
   logic        swc_only_q;
   logic        wd_cause_q;
   logic        cpu_rst;
   logic        sub_rst;
   logic        chip_rst;

   assign soft_req = (wr_stb && hit(bank, off, crw_pkg::BANK_CTRL, crw_pkg::REG_RESET)
                      && avs_byteenable[0] && avs_writedata[crw_pkg::B_RST_FORCE])
                     || wd_fire; // R10 R11
   assign chip_req = wr_stb && hit(bank, off, crw_pkg::BANK_CTRL, crw_pkg::REG_CHIP)
                     && avs_byteenable[0] && avs_writedata[crw_pkg::B_CHIP_RST];
   assign swc_req  = wr_stb && hit(bank, off, crw_pkg::BANK_CTRL, crw_pkg::REG_CHIP)
                     && avs_byteenable[0] && avs_writedata[crw_pkg::B_SWC_RST];
   assign cpu_rst  = cpu_cnt_q != 8'h0;
   assign sub_rst  = sub_cnt_q != 8'h0;
   assign chip_rst = chip_cnt_q != 8'h0;

   // Reset control: protection and cpu-only are sticky; force self-clears
   always_ff @(posedge sys_clk) begin
      if (!resetn || (chip_rst && !reset_q[crw_pkg::B_RST_PROTECT])) begin
         reset_q <= 32'h0;
      end else if (clk_en) begin
         if (wr_stb && hit(bank, off, crw_pkg::BANK_CTRL, crw_pkg::REG_RESET)) begin
            reset_q <= ((reset_q & ~wmask) | (avs_writedata & wmask))
                       & 32'h0000_0006;
         end
      end
   end

   // ----------------------------------------------------------------
   // Reset sequencing
   // ----------------------------------------------------------------
   localparam logic [7:0] PULSE = 8'(RST_PULSE_CYC);

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         cpu_cnt_q <= 8'h0;
         sub_cnt_q <= 8'h0;
      end else if (clk_en) begin
         if (soft_req || (chip_rst && !reset_q[crw_pkg::B_RST_PROTECT])) begin
            cpu_cnt_q <= PULSE; // R2 R6
            if (!reset_q[crw_pkg::B_RST_CPU_ONLY] || chip_rst) begin
               sub_cnt_q <= PULSE; // R2 R3 R14
            end
         end else begin
            if (cpu_rst) begin
               cpu_cnt_q <= cpu_cnt_q - 8'h1;
            end
            if (sub_rst) begin
               sub_cnt_q <= sub_cnt_q - 8'h1;
            end
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         chip_cnt_q <= 8'h0;
         swc_only_q <= 1'b0;
      end else if (clk_en) begin
         if (chip_req || swc_req) begin
            chip_cnt_q <= PULSE; // R6 R7
            swc_only_q <= swc_req && !chip_req; // R7
         end else if (chip_rst) begin
            chip_cnt_q <= chip_cnt_q - 8'h1;
         end
      end
   end

   // Single clock stands in for the processor, memory and system domains
   // Switch register bus slaves only see chip-level reset R5
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         rst_out <= '1;
      end else if (clk_en) begin
         rst_out.cpu         <= cpu_rst;
         rst_out.subsys      <= sub_rst; // R3 R5
         rst_out.switch_core <= chip_rst; // R5 R6
         rst_out.serdes_pll  <= chip_rst && !swc_only_q; // R7
      end
   end

   // ----------------------------------------------------------------
   // Watchdog
   // ----------------------------------------------------------------
   crw_watchdog #(
      .TIMEOUT_CYC (WD_TIMEOUT_CYC)
   ) u_wdog (
      .sys_clk   (sys_clk),
      .resetn    (resetn),
      .clk_en    (clk_en),
      .sub_rst   (cpu_rst),
      .wr        (wr_stb && hit(bank, off, crw_pkg::BANK_CTRL, crw_pkg::REG_WDOG)
                  && avs_byteenable[1]),
      .key       (avs_writedata[crw_pkg::F_WD_KEY_HI:crw_pkg::F_WD_KEY_LO]),
      .enable_in (avs_writedata[crw_pkg::B_WD_ENABLE]),
      .enabled_q (wd_enabled),
      .fire      (wd_fire)
   );

   // Cause remembered from trigger, latched while processor is held
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         wd_cause_q <= 1'b0;
         cause_q    <= 1'b0;
      end else if (clk_en) begin
         if (soft_req || chip_req || swc_req) begin
            wd_cause_q <= wd_fire;
         end
         if (cpu_rst) begin
            cause_q <= wd_cause_q; // R12
         end
      end
   end

   // ----------------------------------------------------------------
   // Bus map control
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!resetn || sub_rst) begin
         general_q    <= crw_pkg::GENERAL_RESET; // R17 R22
         general_wr_q <= crw_pkg::GENERAL_RESET;
      end else if (clk_en) begin
         if (wr_stb && hit(bank, off, crw_pkg::BANK_CTRL, crw_pkg::REG_GENERAL)) begin
            general_wr_q <= ((general_wr_q & ~wmask) | (avs_writedata & wmask))
                            & 32'h0000_0003;
         end
         if (rd_stb && hit(bank, off, crw_pkg::BANK_CTRL, crw_pkg::REG_GENERAL)) begin
            general_q <= general_wr_q; // R19 R24
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn || sub_rst) begin
         large_mem_q <= 1'b0;
      end else if (clk_en) begin
         if (wr_stb && hit(bank, off, crw_pkg::BANK_MISC, crw_pkg::REG_MEMCFG)
             && avs_byteenable[0]) begin
            large_mem_q <= avs_writedata[crw_pkg::B_LARGE_MEM]; // R20
         end
      end
   end

   // Only the external reset clears these
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         scratch_q <= 32'h0; // R8
         pinalt_q  <= 32'h0;
      end else if (clk_en && wr_stb) begin
         if (hit(bank, off, crw_pkg::BANK_MISC, crw_pkg::REG_SCRATCH)) begin
            scratch_q <= (scratch_q & ~wmask) | (avs_writedata & wmask);
         end
         if (hit(bank, off, crw_pkg::BANK_MISC, crw_pkg::REG_PINALT)) begin
            pinalt_q <= (pinalt_q & ~wmask) | (avs_writedata & wmask);
         end
      end
   end

   assign processor_disable_bit = general_q[crw_pkg::B_PROCESSOR_DISABLE_BIT];
   assign boot_map_active       = general_q[crw_pkg::B_BOOT_MAP];

   crw_decoder u_dec (
      .sys_clk   (sys_clk),
      .resetn    (resetn),
      .clk_en    (clk_en),
      .boot_map  (general_q[crw_pkg::B_BOOT_MAP]),
      .large_mem (large_mem_q),
      .req       (bus_req),
      .dec_q     (bus_dec)
   );

   // ----------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         avs_readdata <= 32'h0;
         avs_response <= 2'b00;
      end else if (clk_en && acc && !ack_q) begin
         avs_response <= 2'b00;
         unique case ({bank, off})
            {crw_pkg::BANK_CTRL, crw_pkg::REG_RESET}:   avs_readdata <= reset_q;
            {crw_pkg::BANK_CTRL, crw_pkg::REG_CHIP}:    avs_readdata <= 32'h0;
            {crw_pkg::BANK_CTRL, crw_pkg::REG_WDOG}:
               avs_readdata <= {30'h0, cause_q, wd_enabled};
            {crw_pkg::BANK_CTRL, crw_pkg::REG_GENERAL}: avs_readdata <= general_wr_q;
            {crw_pkg::BANK_MISC, crw_pkg::REG_MEMCFG}:  avs_readdata <= {31'h0, large_mem_q};
            {crw_pkg::BANK_MISC, crw_pkg::REG_SCRATCH}: avs_readdata <= scratch_q;
            {crw_pkg::BANK_MISC, crw_pkg::REG_PINALT}:  avs_readdata <= pinalt_q;
            {crw_pkg::BANK_MISC, crw_pkg::REG_STATUS}:
               avs_readdata <= {28'h0, rst_out};
            default: begin
               avs_readdata <= 32'h0;
               avs_response <= 2'b11;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   cpu_only_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      (clk_en && wd_fire && reset_q[crw_pkg::B_RST_CPU_ONLY] && !sub_rst && !chip_rst)
      |=> !sub_rst && cpu_rst)
      else $error("cpu-only reset reached subsystem"); // R14
   soft_full_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      (clk_en && soft_req && !reset_q[crw_pkg::B_RST_CPU_ONLY]) |=> cpu_rst && sub_rst)
      else $error("soft reset incomplete"); // R2
   map_on_read_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      (clk_en && !sub_rst && !rd_stb && $stable(general_wr_q)) |=> $stable(general_q))
      else $error("map changed outside read"); // R19
   scratch_keep_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      (!wr_stb || !clk_en) |=> $stable(scratch_q))
      else $error("scratch changed by soft reset"); // R8
   serdes_spared_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      (clk_en && swc_req && !chip_req) |=> ##1 (rst_out.switch_core && !rst_out.serdes_pll))
      else $error("serdes hit by switch-core reset"); // R7
endmodule : crw_top

// >>> design/crw_pkg.sv
// Purpose: Constants and types for the subsystem reset, watchdog and bus-map block
// Assumes: One 10 MHz system clock, synchronous active-low reset
// Notes:   Register offsets are byte addresses on the Avalon-MM slave
//
// How it works
// R1 - Processor 500 MHz, memory controller 312.50 MHz, other subsystem logic 250 MHz. The block runs all of these on one 10 MHz sys_clk.
// R2 - Soft-reset request resets processor and whole shared-bus subsystem by default.
// R3 - With cpu-only selected, soft reset hits only the processor core.
// R4 - Software disables frame DMA before any soft reset reaching the subsystem.
// R5 - Switch register bus slaves sit outside the subsystem reset domain.
// R6 - Chip soft reset resets everything, except subsystem when shield set before.
// R7 - Switch-core soft reset acts like chip reset but spares serdes and PLL.
// R8 - Scratch and pin alternate-function registers cleared only by external reset.
// R9 - Watchdog times out two seconds after restart; disabled out of reset.
// R10 - Expiry issues a subsystem soft reset, same as the request bit.
// R11 - A wrong watchdog key write triggers an immediate watchdog reset.
// R12 - Reset-cause flag records watchdog or other; updated only during processor reset.
// R13 - Software writes the key in the same write that sets enable.
// R14 - Cpu-only selection also limits watchdog resets to the processor core.
// R15 - Shared bus is 32-bit address and data, three named masters only.
// R16 - Byte addressing; 8, 16, 32-bit singles and 32-bit word bursts.
// R17 - After power-up or subsystem reset the decoder is in boot mode.
// R18 - Normal mode mirrors DDR into the lowest region instead of flash.
// R19 - Boot-map change is written, then applied at the following read.
// R20 - 512 MB DDR decoded by default; large-memory select gives 1 GB map.
// R21 - Boot mirror 256 MB flash; flash 0x40000000, regs 0x70000000, PCIe 0xC0000000.
// R22 - With cpu-only selected, soft reset leaves the bus mapping unchanged.
// R23 - Watchdog is a down-counter reloaded on each valid enable or restart write.
// R24 - Software may start processor from DDR by clearing boot-map and disable bits.
package crw_pkg;
   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [3:0] REG_RESET   = 4'h0;
   localparam logic [3:0] REG_CHIP    = 4'h4;
   localparam logic [3:0] REG_WDOG    = 4'h8;
   localparam logic [3:0] REG_GENERAL = 4'hc;
   localparam logic [3:0] REG_MEMCFG  = 4'h0;
   localparam logic [3:0] REG_SCRATCH = 4'h4;
   localparam logic [3:0] REG_PINALT  = 4'h8;
   localparam logic [3:0] REG_STATUS  = 4'hc;
   localparam logic       BANK_CTRL   = 1'b0;
   localparam logic       BANK_MISC   = 1'b1;
   // Reset register fields
   localparam int B_RST_FORCE    = 0;
   localparam int B_RST_CPU_ONLY = 1;
   localparam int B_RST_PROTECT  = 2;
   // Chip reset register fields
   localparam int B_CHIP_RST     = 0;
   localparam int B_SWC_RST      = 1;
   // Watchdog register fields
   localparam int B_WD_ENABLE    = 0;
   localparam int B_WD_CAUSE     = 1;
   localparam int F_WD_KEY_LO    = 8;
   localparam int F_WD_KEY_HI    = 15;
   localparam logic [7:0] WD_KEY_FIRST  = 8'hbe;
   localparam logic [7:0] WD_KEY_SECOND = 8'hef;
   // General control and memory-config fields
   localparam int B_BOOT_MAP     = 0;
   localparam int B_PROCESSOR_DISABLE_BIT      = 1;
   localparam int B_LARGE_MEM    = 0;
   localparam logic [31:0] GENERAL_RESET = 32'h0000_0001;
   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam longint CLK_HZ         = 64'd10_000_000;
   localparam longint WD_TIMEOUT_S   = 64'd2;
   localparam longint WD_TIMEOUT_CYC = WD_TIMEOUT_S * CLK_HZ;
   localparam int     RST_PULSE_CYC  = 4;
   // ----------------------------------------------------------------
   // Shared-bus memory map
   // ----------------------------------------------------------------
   localparam logic [31:0] MIRROR_FLASH_TOP = 32'h1000_0000;
   localparam logic [31:0] DDR_LOW_BASE     = 32'h2000_0000;
   localparam logic [31:0] FLASH_BASE       = 32'h4000_0000;
   localparam logic [31:0] FLASH_TOP        = 32'h5000_0000;
   localparam logic [31:0] REGS_BASE        = 32'h7000_0000;
   localparam logic [31:0] REGS_TOP         = 32'h8000_0000;
   localparam logic [31:0] DDR_HI_BASE      = 32'h8000_0000;
   localparam logic [31:0] PCIE_BASE        = 32'hc000_0000;
   localparam logic [31:0] MB512            = 32'h2000_0000;
   localparam logic [31:0] GB1              = 32'h4000_0000;

   typedef enum logic [2:0] {
      CRW_TGT_NONE, CRW_TGT_FLASH, CRW_TGT_DDR, CRW_TGT_REGS, CRW_TGT_PCIE
   } crw_target_t;

   typedef struct packed {
      logic cpu;
      logic subsys;
      logic switch_core;
      logic serdes_pll;
   } crw_resets_t;

   typedef struct packed {
      logic [31:0] addr;
      logic [1:0]  master;
   } crw_bus_req_t;

   typedef struct packed {
      crw_target_t target;
      logic [31:0] offset;
      logic        master_ok;
   } crw_bus_dec_t;
endpackage : crw_pkg

// >>> design/crw_watchdog.sv
// Purpose: Watchdog down-counter with key check
// Assumes: Key and enable arrive together on one write strobe
// Notes:   Expiry and key misuse both raise a one-cycle fire pulse
`timescale 1ns/1ps
module crw_watchdog #(
   parameter longint TIMEOUT_CYC = crw_pkg::WD_TIMEOUT_CYC
) (
   input  wire logic       sys_clk,
   input  wire logic       resetn,
   input  wire logic       clk_en,
   input  wire logic       sub_rst,
   input  wire logic       wr,
   input  wire logic [7:0] key,
   input  wire logic       enable_in,
   output logic            enabled_q,
   output logic            fire
);
   localparam logic [31:0] LOAD = 32'(TIMEOUT_CYC - 64'd1);
   initial begin
      if (TIMEOUT_CYC < 64'd2 || TIMEOUT_CYC > 64'hffff_ffff) begin
         $error("watchdog timeout out of range");
      end
   end

   logic [31:0] count_q;
   logic        armed_q;
   logic        key_ok;
   logic        key_bad;
   logic        expire;

   assign key_ok  = wr && (key == crw_pkg::WD_KEY_SECOND) && armed_q;
   assign key_bad = wr && !(key == crw_pkg::WD_KEY_FIRST) && !key_ok;
   assign expire  = enabled_q && (count_q == 32'h0);
   assign fire    = clk_en && (expire || key_bad); // R10 R11

   // Two-step key sequence
   always_ff @(posedge sys_clk) begin
      if (!resetn || sub_rst) begin
         armed_q <= 1'b0;
      end else if (clk_en && wr) begin
         armed_q <= (key == crw_pkg::WD_KEY_FIRST);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn || sub_rst) begin
         enabled_q <= 1'b0; // R9
         count_q   <= LOAD;
      end else if (clk_en) begin
         if (key_ok) begin
            enabled_q <= enable_in; // R13
            count_q   <= LOAD; // R23
         end else if (expire) begin
            count_q   <= LOAD;
         end else if (enabled_q) begin
            count_q   <= count_q - 32'h1; // R9
         end
      end
   end

   reload_restart_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      (clk_en && key_ok && enable_in && !sub_rst) |=> (enabled_q && count_q == LOAD))
      else $error("watchdog did not reload"); // R23
   expire_fires_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      (clk_en && enabled_q && count_q == 32'h0) |-> fire)
      else $error("expiry did not fire"); // R10
   bad_key_fires_a: assert property (@(posedge sys_clk) disable iff (!resetn)
      (clk_en && wr && key != crw_pkg::WD_KEY_FIRST && key != crw_pkg::WD_KEY_SECOND)
      |-> fire)
      else $error("bad key did not fire"); // R11
endmodule : crw_watchdog

// >>> design/crw_decoder.sv
// Purpose: Shared-bus address decoder for boot and normal maps
// Assumes: Request address is registered by the caller
// Notes:   Unmapped and reserved regions decode to no target
`timescale 1ns/1ps
module crw_decoder (
   input  wire logic                  sys_clk,
   input  wire logic                  resetn,
   input  wire logic                  clk_en,
   input  wire logic                  boot_map,
   input  wire logic                  large_mem,
   input  crw_pkg::crw_bus_req_t      req,
   output crw_pkg::crw_bus_dec_t      dec_q
);
   function automatic crw_pkg::crw_bus_dec_t decode(input logic [31:0] a,
                                                    input logic boot, input logic big);
      crw_pkg::crw_bus_dec_t d;
      d.target    = crw_pkg::CRW_TGT_NONE;
      d.offset    = 32'h0;
      d.master_ok = 1'b1;
      if (a < crw_pkg::MIRROR_FLASH_TOP && boot) begin
         d.target = crw_pkg::CRW_TGT_FLASH; // R17 R21
         d.offset = a;
      end else if (!boot && a < (big ? crw_pkg::GB1 : crw_pkg::MB512)) begin
         d.target = crw_pkg::CRW_TGT_DDR; // R18 R20
         d.offset = a;
      end else if (!big && a >= crw_pkg::DDR_LOW_BASE && a < crw_pkg::FLASH_BASE) begin
         d.target = crw_pkg::CRW_TGT_DDR; // R20
         d.offset = a - crw_pkg::DDR_LOW_BASE;
      end else if (a >= crw_pkg::FLASH_BASE && a < crw_pkg::FLASH_TOP) begin
         d.target = crw_pkg::CRW_TGT_FLASH; // R21
         d.offset = a - crw_pkg::FLASH_BASE;
      end else if (a >= crw_pkg::REGS_BASE && a < crw_pkg::REGS_TOP) begin
         d.target = crw_pkg::CRW_TGT_REGS; // R21
         d.offset = a - crw_pkg::REGS_BASE;
      end else if (big && a >= crw_pkg::DDR_HI_BASE && a < crw_pkg::PCIE_BASE) begin
         d.target = crw_pkg::CRW_TGT_DDR; // R20
         d.offset = a - crw_pkg::DDR_HI_BASE;
      end else if (a >= crw_pkg::PCIE_BASE) begin
         d.target = crw_pkg::CRW_TGT_PCIE; // R21
         d.offset = a - crw_pkg::PCIE_BASE;
      end
      return d;
   endfunction : decode

   // Masters 0..2 only: processor, PCIe inbound, register-access block
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         dec_q <= '0;
      end else if (clk_en) begin
         dec_q           <= decode(req.addr, boot_map, large_mem); // R16
         dec_q.master_ok <= (req.master != 2'd3); // R15
      end
   end
endmodule : crw_decoder

// >>> tb/crw_master_model.sv
// Purpose: Shared-bus master stand-in facing the decoder
// Assumes: Bench picks the address and the master id
// Notes:   Request is registered, as on a real master port
`timescale 1ns/1ps
module crw_master_model (
   input  wire logic             sys_clk,
   input  wire logic [31:0]      addr_in,
   input  wire logic [1:0]       id_in,
   output crw_pkg::crw_bus_req_t req
);
   always_ff @(posedge sys_clk) begin
      req <= '{addr: addr_in, master: id_in};
   end
endmodule : crw_master_model

// >>> tb/crw_top_bench.sv
// Purpose: Self-checking bench for the reset, watchdog and map block
// Assumes: Watchdog shortened to 50 cycles
// Notes:   Boot-map decode cases in a table, normal-map decode and reset cases by hand
`timescale 1ns/1ps
module crw_top_bench;
   typedef struct packed {logic [31:0] a; logic [1:0] m; logic [2:0] t; logic ok;} crw_row_t;
   logic                  sys_clk = 0;
   logic                  resetn = 0;
   logic [4:0]            adr = 0;
   logic                  rd = 0;
   logic                  wr = 0;
   logic [31:0]           wd = 0, rdat, ba = 0, avs_readdata;
   logic [1:0]            bm = 0, resp, avs_response;
   logic                  avs_waitrequest, pdis, bmap;
   crw_pkg::crw_bus_req_t req;
   crw_pkg::crw_bus_dec_t dec;
   crw_pkg::crw_resets_t  rst_out;
   int                    miscompares = 0, checks_done = 0, cyc = 0;
   crw_row_t rows [6] = '{'{32'h0000_0010, 0, 1, 1}, '{32'h1000_0000, 1, 0, 1},
      '{32'h2000_0000, 2, 2, 1}, '{32'h4000_0000, 0, 1, 1}, '{32'h7000_0000, 0, 3, 1},
      '{32'hc000_0000, 3, 4, 0}};
   always #50 sys_clk = ~sys_clk;
   crw_master_model bus_m (.sys_clk(sys_clk), .addr_in(ba), .id_in(bm), .req(req));
   crw_top #(.WD_TIMEOUT_CYC(50), .RST_PULSE_CYC(4)) dut (.sys_clk(sys_clk), .resetn(resetn),
      .clk_en(1'b1), .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
      .avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .avs_response(avs_response), .bus_req(req), .bus_dec(dec), .rst_out(rst_out),
      .processor_disable_bit(pdis), .boot_map_active(bmap));
   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      checks_done++;
      if (s !== e) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic acc(input logic w, input logic [4:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      adr <= a;
      wd <= d;
      rd <= !w;
      wr <= w;
      do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
      rdat = avs_readdata;
      resp = avs_response;
      rd <= 0;
      wr <= 0;
   endtask : acc
   task automatic dchk(input logic [31:0] a, input logic [1:0] m, input logic [2:0] t,
                       input logic ok);
      @(posedge sys_clk);
      ba <= a;
      bm <= m;
      repeat (3) @(posedge sys_clk);
      @(negedge sys_clk);
      chk("target", 32'(dec.target), 32'(t));
      chk("master_ok", 32'(dec.master_ok), 32'(ok));
   endtask : dchk
   task automatic wcpu();
      int n;
      n = 0;
      while (rst_out.cpu !== 1'b1 && n < 80) begin
         @(negedge sys_clk);
         n++;
      end
      chk("cpu_reset", 32'(rst_out.cpu), 32'h1);
   endtask : wcpu
   task automatic print_verdict();
      if (miscompares == 0 && checks_done > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : print_verdict
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 4000) begin
         miscompares++;
         print_verdict();
      end
   end
   initial begin
      repeat (3) @(posedge sys_clk);
      resetn <= 1;
      @(posedge sys_clk);
      @(negedge sys_clk);
      chk("rst_out", 32'(rst_out), 32'h0);
      chk("boot_map", 32'(bmap), 32'h1);
      acc(0, 5'h08, 0);
      chk("wd_enable", 32'(rdat[0]), 32'h0);
      foreach (rows[i]) dchk(rows[i].a, rows[i].m, rows[i].t, rows[i].ok);
      acc(1, 5'h14, 32'h1234_5678);
      acc(1, 5'h0c, 0);
      @(negedge sys_clk);
      chk("boot_map", 32'(bmap), 32'h1);
      acc(0, 5'h0c, 0);
      @(negedge sys_clk);
      chk("boot_map", 32'(bmap), 32'h0);
      dchk(0, 0, 2, 1);
      acc(1, 5'h10, 1);
      dchk(32'h8000_0000, 1, 2, 1);
      acc(1, 5'h00, 1);
      wcpu();
      chk("subsys", 32'(rst_out.subsys), 32'h1);
      repeat (10) @(posedge sys_clk);
      chk("boot_map", 32'(bmap), 32'h1);
      acc(0, 5'h14, 0);
      chk("scratch", rdat, 32'h1234_5678);
      acc(1, 5'h0c, 0);
      acc(0, 5'h0c, 0);
      acc(1, 5'h00, 2);
      acc(1, 5'h00, 3);
      wcpu();
      chk("subsys", 32'(rst_out.subsys), 32'h0);
      repeat (10) @(posedge sys_clk);
      chk("boot_map", 32'(bmap), 32'h0);
      acc(1, 5'h08, 32'h0000_be00);
      acc(1, 5'h08, 32'h0000_ef01);
      wcpu();
      chk("subsys", 32'(rst_out.subsys), 32'h0);
      repeat (10) @(posedge sys_clk);
      acc(0, 5'h08, 0);
      chk("wd_cause", 32'(rdat[1]), 32'h1);
      acc(1, 5'h00, 0);
      acc(1, 5'h08, 32'h0000_1200);
      wcpu();
      repeat (10) @(posedge sys_clk);
      acc(1, 5'h04, 32'h2);
      repeat (2) @(negedge sys_clk);
      chk("switch_core", 32'(rst_out.switch_core), 32'h1);
      chk("serdes_pll", 32'(rst_out.serdes_pll), 32'h0);
      acc(0, 5'h03, 0);
      chk("unmapped", {rdat[29:0], resp}, 32'h3);
      print_verdict();
   end
endmodule : crw_top_bench
